//--- logic/eqc_coef_access.sv
/*
 coefficient store and register access path of the three-band equalizer.
 assumes the register port is driven by the control-bus slave on clk;
 one read or write strobe per cycle, read data wanted the next cycle.
 init clears every word after reset; coefficient writes wait for it.
 power-down and bus timeouts are not modelled; the store never stalls.
 the read window reads as zero while read enable is off.
 coefPointer is brought out for observation only.
*/
`timescale 1ns/1ns
`default_nettype none
module eqc_coef_access #(
	parameter int NUM_COEF = eqc_pkg::COEF_COUNT,
	parameter int DW = eqc_pkg::SAMPLE_WIDTH
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [15:0] regAddr,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	input wire logic [DW-1:0] sampleIn,
	output logic [DW-1:0] eqInput,
	output logic filterRun,
	output logic [$clog2(NUM_COEF)-1:0] coefPointer
);
	import eqc_pkg::*;

	typedef enum logic [2:0] {
		INIT_CLEAR = 3'b001,
		INIT_DONE = 3'b010,
		INIT_IDLE = 3'b100
	} eqc_init_t;

	localparam int PW = $clog2(NUM_COEF);
	localparam logic [PW-1:0] LAST_COEF = PW'(NUM_COEF - 1);

	eqc_init_t initState;
	logic [31:0] coefMem [NUM_COEF];
	logic [23:0] writeLow;
	logic coefWriteEnable;
	logic coefReadEnable;
	logic coefInitComplete;
	logic equalizerInputMute;
	logic [PW-1:0] initIndex;
	logic [31:0] coefReadWord;
	logic enableRise;
	logic writeCommit;
	logic readCommit;

	function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
		hit = (a == ofs);
	endfunction

	function automatic logic [PW-1:0] stepPtr(input logic [PW-1:0] p);
		stepPtr = (p == LAST_COEF) ? '0 : PW'(p + 1'b1);
	endfunction

	// a disabled window gives zero rather than a stale or half-written word
	function automatic logic [7:0] windowByte(input logic [31:0] w, input int idx, input logic en);
		windowByte = en ? w[8*idx+:8] : RST_BYTE;
	endfunction

	// a bit already set does not restart, so rewriting it mid-set is harmless
	// restart pointer when an enable is newly set
	assign enableRise = regWrite && hit(regAddr, OFS_ACCESS_CTRL) &&
		((regWdata[BIT_WRITE_EN] && !coefWriteEnable) ||
		(regWdata[BIT_READ_EN] && !coefReadEnable));
	// top byte completes the word, only while write enabled
	assign writeCommit = regWrite && hit(regAddr, OFS_WR_BYTE3) && coefWriteEnable &&
		coefInitComplete;
	// stepping on the top byte lets four reads walk one word
	// reading the top output byte completes a read word
	assign readCommit = regRead && hit(regAddr, OFS_RD_BYTE3) && coefReadEnable;
	// the pointer never passes NUM_COEF-1, so the index stays in range
	// window shows the pointed coefficient
	assign coefReadWord = coefMem[coefPointer];

	// clear every coefficient, then raise the done flag
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			initState <= INIT_CLEAR;
			initIndex <= '0;
			coefInitComplete <= 1'b0;
		end else begin
			case (initState)
				INIT_CLEAR: begin
					// one word per cycle keeps a single write port on the store
					initIndex <= stepPtr(initIndex);
					if (initIndex == LAST_COEF) begin
						initState <= INIT_DONE;
					end
				end
				INIT_DONE: begin
					coefInitComplete <= 1'b1;
					initState <= INIT_IDLE;
				end
				INIT_IDLE: begin
					coefInitComplete <= 1'b1;
				end
				default: begin
					initState <= INIT_CLEAR;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NUM_COEF; i++) begin
				coefMem[i] <= RST_COEF;
			end
		end else if (initState == INIT_CLEAR) begin
			coefMem[initIndex] <= RST_COEF;
		end else if (writeCommit) begin
			coefMem[coefPointer] <= {regWdata, writeLow};
		end
	end

	// low bytes latch even while writes are off; only the commit is gated
	// hold the three low bytes until the top byte arrives
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			writeLow <= {RST_BYTE, RST_BYTE, RST_BYTE};
		end else if (regWrite) begin
			if (hit(regAddr, OFS_WR_BYTE0)) begin
				writeLow[7:0] <= regWdata;
			end
			if (hit(regAddr, OFS_WR_BYTE1)) begin
				writeLow[15:8] <= regWdata;
			end
			if (hit(regAddr, OFS_WR_BYTE2)) begin
				writeLow[23:16] <= regWdata;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			coefWriteEnable <= 1'b0;
			coefReadEnable <= 1'b0;
		end else if (regWrite && hit(regAddr, OFS_ACCESS_CTRL)) begin
			coefWriteEnable <= regWdata[BIT_WRITE_EN];
			coefReadEnable <= regWdata[BIT_READ_EN];
		end
	end

	// pointer restart and step per whole word
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			coefPointer <= '0;
		end else if (enableRise) begin
			coefPointer <= '0;
		end else if (writeCommit || readCommit) begin
			coefPointer <= stepPtr(coefPointer);
		end
	end

	// limitation: the run bit does not lock out coefficient access
	// run bit, low from reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			filterRun <= 1'b0;
		end else if (regWrite && hit(regAddr, OFS_RUN_CTRL)) begin
			filterRun <= regWdata[BIT_RUN];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			equalizerInputMute <= 1'b0;
		end else if (regWrite && hit(regAddr, OFS_MUTE_CTRL)) begin
			equalizerInputMute <= regWdata[BIT_MUTE];
		end
	end

	// a mute write zeroes on its own edge, so no sample slips through
	// hard zero, no ramp; the mute write takes effect on its own edge
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			eqInput <= '0;
		end else if (equalizerInputMute || (regWrite && hit(regAddr, OFS_MUTE_CTRL) &&
			regWdata[BIT_MUTE])) begin
			eqInput <= '0;
		end else begin
			eqInput <= sampleIn;
		end
	end

	// register read data, one cycle after the read strobe
	// reserved bits and unmapped addresses read as zero
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			regRdata <= RST_BYTE;
		end else if (regRead) begin
			case (regAddr)
				OFS_WR_BYTE0: regRdata <= writeLow[7:0];
				OFS_WR_BYTE1: regRdata <= writeLow[15:8];
				OFS_WR_BYTE2: regRdata <= writeLow[23:16];
				OFS_WR_BYTE3: regRdata <= 8'h00;
				OFS_ACCESS_CTRL: regRdata <= {6'h00, coefWriteEnable, coefReadEnable};
				OFS_RD_BYTE0: regRdata <= windowByte(coefReadWord, 0, coefReadEnable);
				OFS_RD_BYTE1: regRdata <= windowByte(coefReadWord, 1, coefReadEnable);
				OFS_RD_BYTE2: regRdata <= windowByte(coefReadWord, 2, coefReadEnable);
				OFS_RD_BYTE3: regRdata <= windowByte(coefReadWord, 3, coefReadEnable);
				OFS_INIT_STATUS: regRdata <= {7'h00, coefInitComplete};
				OFS_RUN_CTRL: regRdata <= {7'h00, filterRun};
				OFS_MUTE_CTRL: regRdata <= {7'h00, equalizerInputMute};
				default: regRdata <= 8'h00;
			endcase
		end
	end
endmodule
`default_nettype wire

//--- shared/eqc_pkg.sv
/*
 package for the equalizer coefficient access block: register offsets,
 field positions, reset values and sizes.
 assumes a byte-wide register port with 16-bit addresses on one clock.
*/
// Summary of operation
// - four input bytes form one coefficient word
// - top input byte always reads zero
// - writes accepted only with write enable
// - read window live only with read enable
// - read window shows pointed coefficient
// - init done flag rises after initialization
// - run bit starts filter on loaded set
// - run bit resets low, off during access; the block neither forces nor checks this, and run does not gate access
// - mute forces equalizer input to zero
package eqc_pkg;
	localparam logic [15:0] OFS_WR_BYTE0 = 16'h2401;
	localparam logic [15:0] OFS_WR_BYTE1 = 16'h2402;
	localparam logic [15:0] OFS_WR_BYTE2 = 16'h2403;
	localparam logic [15:0] OFS_WR_BYTE3 = 16'h2404;
	localparam logic [15:0] OFS_ACCESS_CTRL = 16'h2406;
	localparam logic [15:0] OFS_RD_BYTE0 = 16'h2407;
	localparam logic [15:0] OFS_RD_BYTE1 = 16'h2408;
	localparam logic [15:0] OFS_RD_BYTE2 = 16'h2409;
	localparam logic [15:0] OFS_RD_BYTE3 = 16'h240A;
	localparam logic [15:0] OFS_INIT_STATUS = 16'h240B;
	localparam logic [15:0] OFS_RUN_CTRL = 16'h240C;
	localparam logic [15:0] OFS_MUTE_CTRL = 16'h240E;
	localparam int BIT_READ_EN = 0;
	localparam int BIT_WRITE_EN = 1;
	localparam int BIT_INIT_DONE = 0;
	localparam int BIT_RUN = 0;
	localparam int BIT_MUTE = 0;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [31:0] RST_COEF = 32'h00000000;
	localparam int COEF_COUNT = 15;
	localparam int SAMPLE_WIDTH = 24;
endpackage

//--- sim/eqc_coef_access_chk.sv
/*
 port checker for the coefficient access block.
 assumes one strobe per cycle; bound to every instance.
*/
`timescale 1ns/1ns
`default_nettype none
module eqc_coef_access_chk #(
	parameter int NUM_COEF = 15,
	parameter int DW = 24
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [15:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic [7:0] regRdata,
	input wire logic [DW-1:0] sampleIn,
	input wire logic [DW-1:0] eqInput,
	input wire logic filterRun,
	input wire logic [$clog2(NUM_COEF)-1:0] coefPointer
);
	logic [1:0] ctrl;
	logic rdStatus;
	logic seenDone;
	logic muteShadow;
	// shadow of the enables; old value is what gates a same-edge access
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) ctrl <= 2'h0;
		else if (regWrite && regAddr == 16'h2406) ctrl <= regWdata[1:0];
	end
	// status data stands the cycle after its read; once seen done it stays done
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdStatus <= 1'b0;
			seenDone <= 1'b0;
		end else begin
			rdStatus <= regRead && regAddr == 16'h240B;
			if (rdStatus && regRdata[0]) seenDone <= 1'b1;
		end
	end
	// shadow of the mute bit, updated like the register itself
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) muteShadow <= 1'b0;
		else if (regWrite && regAddr == 16'h240E) muteShadow <= regWdata[0];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// a top byte write with write enable on, after init, commits one word
	sequence word_commit_s;
		regWrite && regAddr == 16'h2404 && ctrl[1] && seenDone;
	endsequence
	top_byte_zero_a: assert property (regRead && regAddr == 16'h2404 |=> regRdata == 8'h00)
		else $error("top input byte read nonzero");
	run_follows_a: assert property (regWrite && regAddr == 16'h240C |=> filterRun == $past(regWdata[0]))
		else $error("run bit not taken");
	run_hold_a: assert property (!(regWrite && regAddr == 16'h240C) |=> $stable(filterRun))
		else $error("run bit moved");
	mute_zero_a: assert property (regWrite && regAddr == 16'h240E && regWdata[0] |=> eqInput == '0)
		else $error("mute not immediate");
	write_gate_a: assert property (regWrite && regAddr == 16'h2404 && !ctrl[1] |=> $stable(coefPointer))
		else $error("write taken while disabled");
	read_gate_a: assert property (regRead && regAddr >= 16'h2407 && regAddr <= 16'h240A && !ctrl[0]
		|=> regRdata == 8'h00)
		else $error("window live while disabled");
	ptr_step_a: assert property (regRead && regAddr == 16'h240A && ctrl[0] |=> coefPointer ==
		($past(coefPointer) == NUM_COEF - 1 ? '0 : $past(coefPointer) + 1'b1))
		else $error("pointer did not step");
	ptr_restart_a: assert property (regWrite && regAddr == 16'h2406 && (regWdata[1:0] & ~ctrl) != 2'h0
		|=> coefPointer == '0)
		else $error("pointer not restarted");
	commit_step_a: assert property (word_commit_s |=> coefPointer ==
		($past(coefPointer) == NUM_COEF - 1 ? '0 : $past(coefPointer) + 1'b1))
		else $error("pointer did not step on commit");
	done_stays_a: assert property (rdStatus && seenDone |-> regRdata == 8'h01)
		else $error("init done flag dropped");
	pass_through_a: assert property (!muteShadow &&
		!(regWrite && regAddr == 16'h240E && regWdata[0]) |=> eqInput == $past(sampleIn))
		else $error("sample not passed through");
endmodule
bind eqc_coef_access eqc_coef_access_chk #(.NUM_COEF(NUM_COEF), .DW(DW)) chk_i (.clk(clk),
	.rst_b(rst_b), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
	.regWdata(regWdata), .regRdata(regRdata), .sampleIn(sampleIn), .eqInput(eqInput),
	.filterRun(filterRun), .coefPointer(coefPointer));
`default_nettype wire

//--- sim/eqc_coef_access_tb.sv
/*
 testbench for the coefficient access block.
 assumes default parameters: 15 coefficients, 24-bit samples.
*/
`timescale 1ns/1ns
`default_nettype none
module eqc_coef_access_tb;
	logic clk = 0, rst_b = 0, regWrite = 0, regRead = 0;
	logic [15:0] regAddr = 16'h0000;
	logic [7:0] regWdata = 8'h00, regRdata;
	logic [23:0] sampleIn = 24'h000000, eqInput;
	logic filterRun;
	logic [3:0] coefPointer;
	int bad_count = 0, n_compared = 0;
	always #4 clk = ~clk;
	eqc_coef_access dut (.clk(clk), .rst_b(rst_b), .regWrite(regWrite), .regRead(regRead),
		.regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .sampleIn(sampleIn),
		.eqInput(eqInput), .filterRun(filterRun), .coefPointer(coefPointer));
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
			bad_count++;
		end
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk) {regWrite, regAddr, regWdata} = {1'b1, a, d};
		@(negedge clk) regWrite = 0;
	endtask
	task rd(input logic [15:0] a, input logic [7:0] e);
		@(negedge clk) {regRead, regAddr} = {1'b1, a};
		@(negedge clk) regRead = 0;
		chk(regRdata, e);
	endtask
	task wword(input logic [31:0] w);
		for (int i = 0; i < 4; i++) wr(16'(16'h2401 + i), w[8*i+:8]);
	endtask
	task rword(input logic [31:0] w);
		for (int i = 0; i < 4; i++) rd(16'(16'h2407 + i), w[8*i+:8]);
	endtask
	// distinct word per coefficient so a wrong pointer shows up
	function automatic logic [31:0] pat(input int k);
		pat = 32'h11223344 + 32'h01010101 * 32'(k);
	endfunction
	task s_reset;
		chk(filterRun, 0);
		rd(16'h2406, 8'h00);
		rd(16'h240C, 8'h00);
		rd(16'h240B, 8'h00);
	endtask
	// the poll itself compares nothing; only the final value is judged
	task s_init;
		int n;
		n = 0;
		do begin
			@(negedge clk) {regRead, regAddr} = {1'b1, 16'h240B};
			@(negedge clk) regRead = 0;
			n++;
		end while (regRdata !== 8'h01 && n < 40);
		chk(regRdata, 8'h01);
		if (regRdata !== 8'h01) complete_run();
	endtask
	task s_write;
		wword(32'hDEADBEEF);
		chk(coefPointer, 0);
		wr(16'h2406, 8'h02);
		for (int k = 0; k < 15; k++) begin
			wword(pat(k));
			if (k == 1) chk(coefPointer, 2);
		end
		chk(coefPointer, 0);
		chk(filterRun, 0);
	endtask
	task s_read;
		logic [31:0] last;
		last = pat(14);
		wr(16'h2406, 8'h01);
		chk(coefPointer, 0);
		for (int k = 0; k < 15; k++) begin
			rword(pat(k));
			if (k == 0) rd(16'h2404, 8'h00);
			if (k == 1) chk(coefPointer, 2);
		end
		chk(coefPointer, 0);
		rd(16'h2403, last[23:16]);
		wr(16'h2406, 8'h00);
		rd(16'h2407, 8'h00);
		rd(16'h240A, 8'h00);
		chk(coefPointer, 0);
	endtask
	task s_run;
		wr(16'h240C, 8'h01);
		chk(filterRun, 1);
		rd(16'h240C, 8'h01);
		rd(16'h240B, 8'h01);
		wr(16'h240C, 8'h00);
		chk(filterRun, 0);
	endtask
	// unmute lands one edge after the write, as the old mute gates that edge
	task s_mute;
		@(negedge clk) sampleIn = 24'h123456;
		@(negedge clk) chk(eqInput, 24'h123456);
		wr(16'h240E, 8'h01);
		chk(eqInput, 0);
		rd(16'h240E, 8'h01);
		wr(16'h240E, 8'h00);
		@(negedge clk) chk(eqInput, 24'h123456);
	endtask
	task complete_run;
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(negedge clk);
		rst_b = 1;
		s_reset();
		s_init();
		s_write();
		s_read();
		s_run();
		s_mute();
		complete_run();
	end
endmodule
`default_nettype wire
